/* inc/adc_port_pkg.sv */
/*
  shared constants, pin carrier and state codes for the converter host port.
  assumes a single 20 MHz system clock; all host pins arrive asynchronously.
*/
package adc_port_pkg;

  // ------------------------------------------------------------------
  // result format
  // ------------------------------------------------------------------
  localparam int unsigned RESULT_W      = 10;
  localparam int unsigned RESULT_LSB    = 0;           // line carrying bit 1
  localparam int unsigned RESULT_MSB    = 9;           // line carrying bit 10
  localparam logic [9:0]  FULL_SCALE    = 10'h3FF;
  localparam logic [9:0]  ZERO_CODE     = 10'h000;
  localparam int unsigned SAMPLE_W      = 12;          // digitised input width

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned EXT_IDLE_NS   = 2000;        // ext clock high this long -> internal
  localparam int unsigned INT_CLK_NS    = 250;         // internal conversion clock period
  localparam int unsigned EXT_IDLE_CYC  = (EXT_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INT_DIV_CYC   = (INT_CLK_NS / CLK_PERIOD_NS < 1) ? 1 : INT_CLK_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_TICKS    = 11;          // 10 trial bits + transfer

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic        DONE_N_RST    = 1'b1;
  localparam logic        OE_RST        = 1'b0;
  localparam logic        SAMPLING_RST  = 1'b1;
  localparam logic        EXT_MODE_RST  = 1'b0;

  // ------------------------------------------------------------------
  // carriers and states
  // ------------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ext_clk;
  } host_pins_s;

  localparam host_pins_s PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ext_clk: 1'b1};

  typedef enum logic [1:0] {
    ST_TRACK   = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_e;

endpackage

/* core/adc_parallel_host_port.sv */
/*
  control and parallel read-out logic of a 10-bit successive-approximation
  converter: start on write strobe, active-low done flag, tri-state result bus.
  assumes host strobes and the external clock pin are asynchronous to i_clk;
  the analog front end is presented as a digitised sample and two references.
*/
`timescale 1ns/1ps

// Function
// - result bus line 0 carries the least significant bit
// - result bus line 9 carries the most significant bit
// - done goes low once conversion ends and result sits in the latch
// - latch loads the result at the falling edge of done
// - chip select low and read low drive the latch onto the bus
// - read falling edge returns done high
// - write rising edge with chip select low starts a conversion
// - input is held from start until the conversion completes
// - input is tracked whenever no conversion runs
// - input at or above upper reference gives all ones
// - input at or below lower reference gives all zeros
// - strobes are ignored unless chip select is low
// - internal clock when ext clock held high, else the ext clock
module adc_parallel_host_port #(
  parameter int unsigned AW         = adc_port_pkg::SAMPLE_W,
  parameter int unsigned CONV_TICKS = adc_port_pkg::CONV_TICKS
) (
  input  wire logic                                 i_clk,
  input  wire logic                                 i_resetn,
  input  wire logic                                 i_cs_n,
  input  wire logic                                 i_rd_n,
  input  wire logic                                 i_wr_n,
  input  wire logic                                 i_external_clock_in,
  input  wire logic [AW-1:0]                        i_analog_input,
  input  wire logic [AW-1:0]                        i_ref_upper,
  input  wire logic [AW-1:0]                        i_ref_lower,
  output logic      [adc_port_pkg::RESULT_W-1:0]    o_data,
  output logic      [adc_port_pkg::RESULT_W-1:0]    o_data_oe,
  output logic                                      o_conv_done_n,
  output logic                                      o_sampling,
  output logic                                      o_ext_clock_mode
);

  // ------------------------------------------------------------------
  // local widths and state record
  // ------------------------------------------------------------------
  localparam int unsigned RW   = adc_port_pkg::RESULT_W;
  localparam int unsigned IW   = $clog2(adc_port_pkg::EXT_IDLE_CYC + 1);
  localparam int unsigned DW   = $clog2(adc_port_pkg::INT_DIV_CYC + 1);
  localparam int unsigned TW   = $clog2(CONV_TICKS + 1);
  localparam int unsigned PW   = AW + RW;
  localparam logic [IW-1:0] IDLE_LAST = IW'(adc_port_pkg::EXT_IDLE_CYC - 1);
  localparam logic [DW-1:0] DIV_LAST  = DW'(adc_port_pkg::INT_DIV_CYC - 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(CONV_TICKS - 1);

  typedef struct packed {
    adc_port_pkg::host_pins_s  meta;
    adc_port_pkg::host_pins_s  sync;
    adc_port_pkg::host_pins_s  prev;
    adc_port_pkg::conv_state_e state;
    logic                      ext_mode;
    logic [IW-1:0]             idle_cnt;
    logic [DW-1:0]             div_cnt;
    logic [TW-1:0]             tick_cnt;
    logic [RW-1:0]             code;
    logic [AW-1:0]             held;
    logic [RW-1:0]             latch;
    logic                      oe;
    logic                      done_n;
    logic                      sampling;
  } port_state_s;

  port_state_s st_q;
  port_state_s st_d;

  // one successive-approximation trial: keep the bit if the trial level fits
  function automatic logic sar_keep(input logic [AW-1:0] held,
                                    input logic [AW-1:0] lo,
                                    input logic [AW-1:0] hi,
                                    input logic [RW-1:0] trial);
    logic [PW-1:0] lhs;
    logic [PW-1:0] rhs;
    lhs = PW'(held - lo) << RW;
    rhs = PW'(trial) * PW'(hi - lo);
    return (lhs >= rhs);
  endfunction

  // ------------------------------------------------------------------
  // decoded events
  // ------------------------------------------------------------------
  logic           rd_fall;
  logic           wr_rise;
  logic           conv_tick;
  logic [RW-1:0]  trial;
  logic [RW-1:0]  result;
  logic [RW-1:0]  code_next;
  logic           last_tick;

  // strobe edges only count with chip select low
  always_comb begin
    rd_fall   = st_q.prev.rd_n && !st_q.sync.rd_n && !st_q.sync.cs_n;
    wr_rise   = !st_q.prev.wr_n && st_q.sync.wr_n && !st_q.sync.cs_n;
    conv_tick = st_q.ext_mode ? (st_q.sync.ext_clk && !st_q.prev.ext_clk)
                              : (st_q.div_cnt == DIV_LAST);
    last_tick = conv_tick && (st_q.tick_cnt == TICK_LAST);
    trial     = '0;
    if (st_q.tick_cnt < TW'(RW)) begin
      trial = st_q.code | (RW'(1) << (RW - 1 - 32'(st_q.tick_cnt)));
    end
    // trial decided on this tick; the latch reads it so a ten-tick count keeps the lsb
    code_next = st_q.code;
    if (conv_tick && st_q.state == adc_port_pkg::ST_CONVERT && st_q.tick_cnt < TW'(RW) &&
        sar_keep(st_q.held, i_ref_lower, i_ref_upper, trial)) begin
      code_next = trial;
    end
  end

  // final code with explicit clamps at both references
  // the code includes the decision of the current tick, as that tick may also be the transfer
  always_comb begin
    if (st_q.held >= i_ref_upper) begin
      result = adc_port_pkg::FULL_SCALE;
    end else if (st_q.held <= i_ref_lower) begin
      result = adc_port_pkg::ZERO_CODE;
    end else begin
      result = code_next;
    end
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.meta = '{cs_n: i_cs_n, rd_n: i_rd_n, wr_n: i_wr_n, ext_clk: i_external_clock_in};
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;

    // clock source pick: any low on the pin selects it, long high falls back
    if (!st_q.sync.ext_clk) begin
      st_d.idle_cnt = '0;
      st_d.ext_mode = 1'b1;
    end else if (st_q.idle_cnt == IDLE_LAST) begin
      st_d.ext_mode = 1'b0;
    end else begin
      st_d.idle_cnt = st_q.idle_cnt + IW'(1);
    end

    // free-running internal conversion clock
    st_d.div_cnt = (st_q.div_cnt == DIV_LAST) ? '0 : st_q.div_cnt + DW'(1);

    // bus enable follows chip select and read
    st_d.oe = !st_q.sync.cs_n && !st_q.sync.rd_n;

    // read clears done; completion below overrides it in the same cycle
    if (rd_fall) begin
      st_d.done_n = 1'b1;
    end

    case (st_q.state)
      adc_port_pkg::ST_TRACK: begin
        st_d.held     = i_analog_input;
        st_d.sampling = 1'b1;
        if (wr_rise) begin
          st_d.state    = adc_port_pkg::ST_CONVERT;
          st_d.held     = st_q.held;
          st_d.sampling = 1'b0;
          st_d.tick_cnt = '0;
          st_d.code     = '0;
        end
      end
      adc_port_pkg::ST_CONVERT: begin
        if (conv_tick) begin
          st_d.tick_cnt = st_q.tick_cnt + TW'(1);
          st_d.code     = code_next;
        end
        if (last_tick) begin
          st_d.latch    = result;
          st_d.done_n   = 1'b0;
          st_d.state    = adc_port_pkg::ST_TRACK;
          st_d.sampling = 1'b1;
        end
      end
      default: begin
        st_d.state = adc_port_pkg::ST_TRACK;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q          <= '0;
      st_q.meta     <= adc_port_pkg::PINS_IDLE;
      st_q.sync     <= adc_port_pkg::PINS_IDLE;
      st_q.prev     <= adc_port_pkg::PINS_IDLE;
      st_q.state    <= adc_port_pkg::ST_TRACK;
      st_q.ext_mode <= adc_port_pkg::EXT_MODE_RST;
      st_q.oe       <= adc_port_pkg::OE_RST;
      st_q.done_n   <= adc_port_pkg::DONE_N_RST;
      st_q.sampling <= adc_port_pkg::SAMPLING_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops; bit 0 is the lsb, bit 9 the msb
  assign o_data           = st_q.latch;
  assign o_data_oe        = {RW{st_q.oe}};
  assign o_conv_done_n    = st_q.done_n;
  assign o_sampling       = st_q.sampling;
  assign o_ext_clock_mode = st_q.ext_mode;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_bus_drive;
    (!st_q.sync.cs_n && !st_q.sync.rd_n) |=> (o_data_oe == {RW{1'b1}});
  endproperty
  a_bus_drive: assert property (p_bus_drive) else $error("bus not driven on read");

  property p_bus_float;
    (st_q.sync.cs_n || st_q.sync.rd_n) |=> (o_data_oe == '0);
  endproperty
  a_bus_float: assert property (p_bus_float) else $error("bus driven outside read");

  property p_read_clears_done;
    (rd_fall && !last_tick) |=> o_conv_done_n;
  endproperty
  a_read_clears_done: assert property (p_read_clears_done) else $error("read left done low");

  property p_done_after_conv;
    $fell(o_conv_done_n) |-> $past(st_q.state) == adc_port_pkg::ST_CONVERT
                             && $past(st_q.tick_cnt) == TICK_LAST;
  endproperty
  a_done_after_conv: assert property (p_done_after_conv) else $error("done fell early");

  property p_latch_on_done;
    $fell(o_conv_done_n) |-> o_data == $past(result);
  endproperty
  a_latch_on_done: assert property (p_latch_on_done) else $error("latch missed result");

  property p_start;
    (wr_rise && st_q.state == adc_port_pkg::ST_TRACK) |=>
      st_q.state == adc_port_pkg::ST_CONVERT && !o_sampling;
  endproperty
  a_start: assert property (p_start) else $error("write did not start");

  property p_cs_gate;
    (st_q.sync.cs_n && st_q.state == adc_port_pkg::ST_TRACK) |=>
      st_q.state == adc_port_pkg::ST_TRACK;
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("strobe taken without select");

  property p_hold;
    (st_q.state == adc_port_pkg::ST_CONVERT) ##1 (st_q.state == adc_port_pkg::ST_CONVERT)
      |-> $stable(st_q.held);
  endproperty
  a_hold: assert property (p_hold) else $error("sample moved during conversion");

  property p_track;
    (st_q.state == adc_port_pkg::ST_TRACK && !wr_rise) |=> o_sampling && st_q.held == $past(i_analog_input);
  endproperty
  a_track: assert property (p_track) else $error("input not tracked");

  property p_full_scale;
    $fell(o_conv_done_n) && $past(st_q.held >= i_ref_upper) |-> o_data == adc_port_pkg::FULL_SCALE;
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("full scale code wrong");

  property p_zero_scale;
    $fell(o_conv_done_n) && $past(st_q.held <= i_ref_lower && st_q.held < i_ref_upper)
      |-> o_data == adc_port_pkg::ZERO_CODE;
  endproperty
  a_zero_scale: assert property (p_zero_scale) else $error("zero code wrong");

  property p_ext_select;
    !st_q.sync.ext_clk |=> o_ext_clock_mode;
  endproperty
  a_ext_select: assert property (p_ext_select) else $error("ext clock not selected");

  // done low stands until a read strobe takes it back high
  property p_done_holds;
    (!o_conv_done_n && !rd_fall) |=> !o_conv_done_n;
  endproperty
  a_done_holds: assert property (p_done_holds) else $error("done rose without read");

  // a write strobe during a conversion neither restarts nor ends it
  property p_busy_ignore;
    (st_q.state == adc_port_pkg::ST_CONVERT && !last_tick) |=> st_q.state == adc_port_pkg::ST_CONVERT;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("conversion left early");

  // main scenarios: conversion, read back, external clock, busy write, deselected read
  c_conversion: cover property ($fell(o_conv_done_n));
  c_busy_write: cover property (st_q.state == adc_port_pkg::ST_CONVERT && wr_rise);
  c_no_select:  cover property (!st_q.sync.rd_n && st_q.sync.cs_n);
  c_read_back:  cover property (!o_conv_done_n ##1 rd_fall ##1 o_conv_done_n);
  c_ext_conv:   cover property (o_ext_clock_mode && $fell(o_conv_done_n));

endmodule // adc_parallel_host_port

/* bench/host_model.sv */
/*
  host-side model: drives chip select, both strobes and the external clock pin,
  and shows the data lines as a host sees them (floating lines do not hold).
  assumes the bench calls its tasks; every pin change lands on a falling edge.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic       i_clk,
  input  wire logic [9:0] i_data,
  input  wire logic [9:0] i_data_oe,
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic            o_ext_clk,
  output logic [9:0]      o_bus
);
  logic [9:0] last_q;

  // pins idle high, ext clock held high selects the internal clock
  initial begin
    {o_cs_n, o_rd_n, o_wr_n, o_ext_clk} = 4'hF;
    last_q = 10'h000;
  end

  // a released line shows the inverse of its last driven level
  always @(posedge i_clk) last_q <= (i_data & i_data_oe) | (last_q & ~i_data_oe);
  assign o_bus = (i_data & i_data_oe) | (~last_q & ~i_data_oe);

  // hold a level long enough for the synchroniser
  task automatic wait3();
    repeat (3) @(negedge i_clk);
  endtask

  // start pulse framed by chip select when sel is set
  task automatic start_conv(input logic sel);
    @(negedge i_clk);
    o_cs_n = ~sel;
    wait3();
    o_wr_n = 1'b0;
    wait3();
    o_wr_n = 1'b1;
    wait3();
    o_cs_n = 1'b1;
  endtask

  task automatic read_open(input logic sel);
    @(negedge i_clk);
    o_cs_n = ~sel;
    wait3();
    o_rd_n = 1'b0;
  endtask

  task automatic read_close();
    @(negedge i_clk);
    o_rd_n = 1'b1;
    wait3();
    o_cs_n = 1'b1;
  endtask

  task automatic set_ext(input logic v);
    @(negedge i_clk);
    o_ext_clk = v;
  endtask

  // n ext clock periods, four clocks low then four high
  task automatic ext_ticks(input int n);
    repeat (n) begin
      repeat (4) @(negedge i_clk);
      o_ext_clk = 1'b1;
      repeat (4) @(negedge i_clk);
      o_ext_clk = 1'b0;
    end
  endtask
endmodule // host_model

/* bench/tb_adc_parallel_host_port.sv */
/*
  self-checking bench for the converter host port, driven through a host model.
  assumes a 20 MHz clock and a shortened count of ten conversion ticks.
*/
`timescale 1ns/1ps
module tb_adc_parallel_host_port;
  localparam int unsigned TICKS = 10;
  logic        i_clk;
  logic        i_resetn;
  logic [11:0] analog_input, ref_hi, ref_lo;
  logic [9:0]  o_data, o_data_oe, bus;
  logic        cs_n, rd_n, wr_n, ext_clk;
  logic        o_conv_done_n, o_sampling, o_ext_clock_mode;
  int          miscompares, check_count;

  adc_parallel_host_port #(
    .CONV_TICKS(TICKS)
  ) uut (
    .i_clk              (i_clk),
    .i_resetn           (i_resetn),
    .i_cs_n             (cs_n),
    .i_rd_n             (rd_n),
    .i_wr_n             (wr_n),
    .i_external_clock_in(ext_clk),
    .i_analog_input     (analog_input),
    .i_ref_upper        (ref_hi),
    .i_ref_lower        (ref_lo),
    .o_data             (o_data),
    .o_data_oe          (o_data_oe),
    .o_conv_done_n      (o_conv_done_n),
    .o_sampling         (o_sampling),
    .o_ext_clock_mode   (o_ext_clock_mode)
  );

  host_model host (
    .i_clk    (i_clk),
    .i_data   (o_data),
    .i_data_oe(o_data_oe),
    .o_cs_n   (cs_n),
    .o_rd_n   (rd_n),
    .o_wr_n   (wr_n),
    .o_ext_clk(ext_clk),
    .o_bus    (bus)
  );

  // ------------------------------------------------------------------
  // compare and wait helpers
  // ------------------------------------------------------------------
  always #25 i_clk = ~i_clk;

  task automatic chk_vec(input string what, input logic [9:0] exp, input logic [9:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_vec(what, {9'h000, exp}, {9'h000, got});
  endtask

  // bounded wait for a flag to reach a level
  task automatic wait_for(ref logic sig, input logic lvl, input int limit);
    int n;
    n = 0;
    while (sig !== lvl && n < limit) begin
      @(negedge i_clk);
      n++;
    end
  endtask

  // open a read, judge bus and flags, close it and see the bus float
  task automatic read_check(input logic [9:0] exp);
    host.read_open(1'b1);
    repeat (5) @(negedge i_clk);
    chk_vec("oe", 10'h3FF, o_data_oe);
    chk_vec("bus", exp, bus);
    chk_bit("lsb", exp[0], bus[0]);
    chk_bit("msb", exp[9], bus[9]);
    chk_bit("done_n", 1'b1, o_conv_done_n);
    host.read_close();
    repeat (2) @(negedge i_clk);
    chk_vec("oe", 10'h000, o_data_oe);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk_bit("done_n", 1'b1, o_conv_done_n);
    chk_bit("sampling", 1'b1, o_sampling);
    chk_bit("ext_mode", 1'b0, o_ext_clock_mode);
    chk_vec("oe", 10'h000, o_data_oe);
  endtask

  // a second start and an input change mid-conversion must not disturb the result
  task automatic t_convert(input logic [11:0] val, input logic [9:0] exp);
    analog_input = val;
    host.start_conv(1'b1);
    wait_for(o_sampling, 1'b0, 20);
    chk_bit("sampling", 1'b0, o_sampling);
    analog_input = ~val;
    host.start_conv(1'b1);
    wait_for(o_conv_done_n, 1'b0, 300);
    chk_bit("done_n", 1'b0, o_conv_done_n);
    chk_bit("sampling", 1'b1, o_sampling);
    read_check(exp);
  endtask

  // deselected strobes leave a pending done, the sampler and the bus alone
  task automatic t_deselect();
    analog_input = 12'h400;
    host.start_conv(1'b1);
    wait_for(o_conv_done_n, 1'b0, 300);
    host.start_conv(1'b0);
    host.read_open(1'b0);
    repeat (5) @(negedge i_clk);
    chk_vec("oe", 10'h000, o_data_oe);
    chk_bit("sampling", 1'b1, o_sampling);
    chk_bit("done_n", 1'b0, o_conv_done_n);
    host.read_close();
    read_check(10'h200);
  endtask

  // reset in mid-conversion: flags back to reset values and the latch cleared
  task automatic t_midreset();
    analog_input = 12'h54B;
    host.start_conv(1'b1);
    repeat (10) @(negedge i_clk);
    i_resetn = 1'b0;
    repeat (2) @(negedge i_clk);
    i_resetn = 1'b1;
    @(negedge i_clk);
    t_reset();
    read_check(10'h000);
  endtask

  // conversion counted on external clock edges, then back to internal
  task automatic t_external();
    host.set_ext(1'b0);
    repeat (4) @(negedge i_clk);
    chk_bit("ext_mode", 1'b1, o_ext_clock_mode);
    analog_input = 12'h54B;
    host.start_conv(1'b1);
    wait_for(o_sampling, 1'b0, 20);
    host.ext_ticks(TICKS - 1);
    chk_bit("done_n", 1'b1, o_conv_done_n);
    host.ext_ticks(1);
    chk_bit("done_n", 1'b0, o_conv_done_n);
    read_check(10'h2A5);
    host.set_ext(1'b1);
    repeat (adc_port_pkg::EXT_IDLE_CYC - 10) @(negedge i_clk);
    chk_bit("ext_mode", 1'b1, o_ext_clock_mode);
    repeat (20) @(negedge i_clk);
    chk_bit("ext_mode", 1'b0, o_ext_clock_mode);
  endtask

  // ------------------------------------------------------------------
  // sequence, watchdog and verdict
  // ------------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence: reset, mid-scale codes, clamping, deselect, external clock
  initial begin
    i_clk = 1'b0;
    i_resetn = 1'b0;
    analog_input = 12'h000;
    ref_hi = 12'h800;
    ref_lo = 12'h000;
    miscompares = 0;
    check_count = 0;
    repeat (6) @(negedge i_clk);
    i_resetn = 1'b1;
    @(negedge i_clk);
    t_reset();
    t_convert(12'h54B, 10'h2A5);
    t_convert(12'h2A5, 10'h152);
    ref_hi = 12'h900;
    ref_lo = 12'h100;
    t_convert(12'h900, 10'h3FF);
    t_convert(12'hFFF, 10'h3FF);
    t_convert(12'h100, 10'h000);
    t_convert(12'h000, 10'h000);
    ref_hi = 12'h800;
    ref_lo = 12'h000;
    t_deselect();
    t_midreset();
    t_external();
    conclude();
  end

  // watchdog on a span well beyond the expected run
  initial begin
    #250000;
    miscompares++;
    conclude();
  end
endmodule // tb_adc_parallel_host_port
